// ==== inc/pcch_consts.svh ====
`ifndef PCCH_CONSTS_SVH
`define PCCH_CONSTS_SVH

// Byte offsets of the header words
`define PCCH_OFF_IDENT 8'h00
`define PCCH_OFF_STSCMD 8'h04
`define PCCH_OFF_CLASS 8'h08
`define PCCH_OFF_MISC 8'h0C
`define PCCH_OFF_BASE 8'h10
`define PCCH_OFF_SUBSYS 8'h2C
`define PCCH_OFF_INTR 8'h3C

// Field positions in the status and command word
`define PCCH_STS_PERR 31
`define PCCH_STS_SERR 30
`define PCCH_STS_CAPLIST 20
`define PCCH_CMD_INTX_DIS 10
`define PCCH_CMD_SERR_EN 8
`define PCCH_CMD_PERR_EN 6
`define PCCH_CMD_MEM_EN 1
`define PCCH_CMD_IO_EN 0

// Window base: bits 31 to 14 writable, 16K claimed
`define PCCH_BASE_LSB 14

// Reset and default values
`define PCCH_CLASS_DEFAULT 24'h070002
`define PCCH_SUBSYS_RESET 16'h0000
`define PCCH_INT_PIN 8'h01
`define PCCH_INT_LINE_RESET 8'h00

// Loadable word slots in the shadow memory
`define PCCH_EW_MAKER 3'h0
`define PCCH_EW_DEVICE 3'h1
`define PCCH_EW_CLASS_HI 3'h2
`define PCCH_EW_CLASS_LO 3'h3
`define PCCH_EW_SUB_MAKER 3'h4
`define PCCH_EW_SUB_ID 3'h5

`endif

// ==== inc/pcch_pkg.sv ====
package pcch_pkg;

	// Kind of slave attached at the expansion interface
	typedef enum logic [1:0] {
		PCCH_SLV_NONE = 2'b00,
		PCCH_SLV_EIGHT = 2'b01,
		PCCH_SLV_FOUR = 2'b10
	} pcch_slave_t;

	// Whole state of the header register bank
	typedef struct packed {
		logic cmd_intx_dis;
		logic cmd_serr_en;
		logic cmd_perr_en;
		logic cmd_mem_en;
		logic sts_perr;
		logic sts_serr;
		logic [17:0] base;
		logic [7:0] int_line;
		logic [7:0] loaded;
		logic rd_pend;
		logic [7:0] rd_addr;
		logic ack;
		logic [31:0] rdata;
		logic intx;
		logic serr;
		logic perr_resp;
		logic claim;
	} pcch_state_t;

endpackage : pcch_pkg

// ==== inc/pcch_mem_if.sv ====
interface pcch_mem_if #(
	parameter int W = 16,
	parameter int AW = 3
);
	logic wr_en;
	logic [AW-1:0] wr_idx;
	logic [W-1:0] wr_data;
	logic [AW-1:0] rd_idx_a;
	logic [AW-1:0] rd_idx_b;
	logic [W-1:0] rd_data_a;
	logic [W-1:0] rd_data_b;

	modport ctrl (
		output wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b,
		input rd_data_a, rd_data_b
	);
	modport mem (
		input wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b,
		output rd_data_a, rd_data_b
	);
endinterface : pcch_mem_if

// ==== hw/pcch_word_mem.sv ====
// Shadow store for words loaded from the serial EEPROM
module pcch_word_mem #(
	parameter int W = 16,
	parameter int AW = 3
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Access from the register bank
	pcch_mem_if.mem mp
);
	localparam int DEPTH = 1 << AW;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] words;
		logic [W-1:0] rd_a;
		logic [W-1:0] rd_b;
	} pcch_mem_state_t;

	pcch_mem_state_t st;
	pcch_mem_state_t next_st;

	// Write port plus two registered read ports; reads see old data
	always_comb begin
		next_st = st;
		if (mp.wr_en) begin
			next_st.words[mp.wr_idx] = mp.wr_data;
		end
		next_st.rd_a = st.words[mp.rd_idx_a];
		next_st.rd_b = st.words[mp.rd_idx_b];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign mp.rd_data_a = st.rd_a;
	assign mp.rd_data_b = st.rd_b;

endmodule : pcch_word_mem

// ==== hw/pcch_cfg_regs.sv ====
// Overview of operation
// - Device code follows attached expansion slave kind
// - Maker code defaults, replaceable from EEPROM
// - Parity status sets on error, write-one clears
// - System error status sets, write-one clears
// - Other status bits zero, capability bit one
// - Interrupt disable bit blocks legacy interrupt
// - System error enable gates error signalling
// - Parity enable gates parity error response
// - Memory accesses accepted only when enabled
// - I/O enable reads zero, never respond
// - Class code default, EEPROM may override
// - Low class byte returns silicon revision
// - Word at twelve reads all zero
// - Base bits 31:14 writable, low zero
// - Load six EEPROM words over defaults
// - Subsystem fields reset zero, EEPROM loadable
// - Interrupt pin reads one, line writable
`include "pcch_consts.svh"

module pcch_cfg_regs #(
	parameter logic [15:0] MAKER_ID = 16'h5A5A, // arbitrary value
	parameter logic [15:0] DEV_ID_SOLO = 16'h0100, // arbitrary value
	parameter logic [15:0] DEV_ID_X8 = 16'h0108, // arbitrary value
	parameter logic [15:0] DEV_ID_X4 = 16'h0104, // arbitrary value
	parameter logic [7:0] REV_ID = 8'h01 // arbitrary value
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Configuration access port
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	// EEPROM word load
	input wire logic ee_valid,
	input wire logic [2:0] ee_index,
	input wire logic [15:0] ee_data,
	// Expansion strap
	input wire logic [1:0] exp_slave,
	// Memory window requests
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_claim,
	// Error and interrupt events
	input wire logic parity_err_det,
	input wire logic sys_err_det,
	input wire logic uart_irq,
	output logic intx_out,
	output logic serr_out,
	output logic perr_resp
);

	pcch_pkg::pcch_state_t st;
	pcch_pkg::pcch_state_t next_st;
	pcch_mem_if #(.W(16), .AW(3)) mif ();

	// Whole 24-bit class default, so each byte can be sliced explicitly
	localparam logic [23:0] CLASS_DEF = `PCCH_CLASS_DEFAULT;

	logic rd_take;
	logic wr_take;
	logic [15:0] dev_default;
	logic [31:0] rd_word;

	pcch_word_mem #(
		.W(16),
		.AW(3)
	) u_mem (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.mp(mif.mem)
	);

	// Requests are ignored while a read is in flight
	assign rd_take = cfg_req && !cfg_we && !st.rd_pend;
	assign wr_take = cfg_req && cfg_we && !st.rd_pend;

	// EEPROM words go straight into the shadow store
	assign mif.wr_en = ee_valid;
	assign mif.wr_idx = ee_index;
	assign mif.wr_data = ee_data;

	// Read ports pick the two halves of the addressed word
	always_comb begin
		unique case (cfg_addr)
			`PCCH_OFF_CLASS: begin
				mif.rd_idx_a = `PCCH_EW_CLASS_LO;
				mif.rd_idx_b = `PCCH_EW_CLASS_HI;
			end
			`PCCH_OFF_SUBSYS: begin
				mif.rd_idx_a = `PCCH_EW_SUB_MAKER;
				mif.rd_idx_b = `PCCH_EW_SUB_ID;
			end
			default: begin
				mif.rd_idx_a = `PCCH_EW_MAKER;
				mif.rd_idx_b = `PCCH_EW_DEVICE;
			end
		endcase
	end

	// Strap decides the device code; the unused code acts as no slave
	always_comb begin
		unique case (exp_slave)
			pcch_pkg::PCCH_SLV_EIGHT: dev_default = DEV_ID_X8;
			pcch_pkg::PCCH_SLV_FOUR: dev_default = DEV_ID_X4;
			default: dev_default = DEV_ID_SOLO;
		endcase
	end

	// Compose read data; loaded words replace the defaults
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (st.rd_addr)
			`PCCH_OFF_IDENT: begin
				rd_word[31:16] = st.loaded[`PCCH_EW_DEVICE] ?
					mif.rd_data_b : dev_default;
				rd_word[15:0] = st.loaded[`PCCH_EW_MAKER] ?
					mif.rd_data_a : MAKER_ID;
			end
			`PCCH_OFF_STSCMD: begin
				rd_word[`PCCH_STS_PERR] = st.sts_perr;
				rd_word[`PCCH_STS_SERR] = st.sts_serr;
				rd_word[`PCCH_STS_CAPLIST] = 1'b1;
				rd_word[`PCCH_CMD_INTX_DIS] = st.cmd_intx_dis;
				rd_word[`PCCH_CMD_SERR_EN] = st.cmd_serr_en;
				rd_word[`PCCH_CMD_PERR_EN] = st.cmd_perr_en;
				rd_word[`PCCH_CMD_MEM_EN] = st.cmd_mem_en;
				rd_word[`PCCH_CMD_IO_EN] = 1'b0;
			end
			`PCCH_OFF_CLASS: begin
				rd_word[31:16] = st.loaded[`PCCH_EW_CLASS_HI] ?
					mif.rd_data_b : CLASS_DEF[23:8];
				rd_word[15:8] = st.loaded[`PCCH_EW_CLASS_LO] ?
					mif.rd_data_a[15:8] : CLASS_DEF[7:0];
				rd_word[7:0] = REV_ID;
			end
			`PCCH_OFF_BASE: begin
				rd_word[31:`PCCH_BASE_LSB] = st.base;
			end
			`PCCH_OFF_SUBSYS: begin
				rd_word[31:16] = st.loaded[`PCCH_EW_SUB_ID] ?
					mif.rd_data_b : `PCCH_SUBSYS_RESET;
				rd_word[15:0] = st.loaded[`PCCH_EW_SUB_MAKER] ?
					mif.rd_data_a : `PCCH_SUBSYS_RESET;
			end
			`PCCH_OFF_INTR: begin
				rd_word[15:8] = `PCCH_INT_PIN;
				rd_word[7:0] = st.int_line;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Next state: writes, sticky flags, gated outputs and claims
	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		if (ee_valid) begin
			next_st.loaded[ee_index] = 1'b1;
		end
		if (rd_take) begin
			next_st.rd_pend = 1'b1;
			next_st.rd_addr = cfg_addr;
		end
		if (st.rd_pend) begin
			next_st.rd_pend = 1'b0;
			next_st.ack = 1'b1;
			next_st.rdata = rd_word;
		end
		if (wr_take) begin
			next_st.ack = 1'b1;
			if (cfg_addr == `PCCH_OFF_STSCMD) begin
				if (cfg_be[1]) begin
					next_st.cmd_intx_dis = cfg_wdata[`PCCH_CMD_INTX_DIS];
					next_st.cmd_serr_en = cfg_wdata[`PCCH_CMD_SERR_EN];
				end
				if (cfg_be[0]) begin
					next_st.cmd_perr_en = cfg_wdata[`PCCH_CMD_PERR_EN];
					next_st.cmd_mem_en = cfg_wdata[`PCCH_CMD_MEM_EN];
				end
				if (cfg_be[3] && cfg_wdata[`PCCH_STS_PERR]) begin
					next_st.sts_perr = 1'b0;
				end
				if (cfg_be[3] && cfg_wdata[`PCCH_STS_SERR]) begin
					next_st.sts_serr = 1'b0;
				end
			end
			// The host loads the window before using it
			if (cfg_addr == `PCCH_OFF_BASE) begin
				if (cfg_be[1]) begin
					next_st.base[1:0] = cfg_wdata[15:14];
				end
				if (cfg_be[2]) begin
					next_st.base[9:2] = cfg_wdata[23:16];
				end
				if (cfg_be[3]) begin
					next_st.base[17:10] = cfg_wdata[31:24];
				end
			end
			if (cfg_addr == `PCCH_OFF_INTR && cfg_be[0]) begin
				next_st.int_line = cfg_wdata[7:0];
			end
		end
		// Set after clear so an event in the clearing cycle survives
		if (parity_err_det) begin
			next_st.sts_perr = 1'b1;
		end
		if (sys_err_det) begin
			next_st.sts_serr = 1'b1;
		end
		next_st.intx = uart_irq && !st.cmd_intx_dis;
		next_st.serr = sys_err_det && st.cmd_serr_en;
		next_st.perr_resp = parity_err_det && st.cmd_perr_en;
		// No I/O port exists, so nothing is ever claimed in I/O space
		next_st.claim = mem_req && st.cmd_mem_en &&
			(mem_addr[31:`PCCH_BASE_LSB] == st.base);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Every output is a register bit
	assign cfg_ack = st.ack;
	assign cfg_rdata = st.rdata;
	assign mem_claim = st.claim;
	assign intx_out = st.intx;
	assign serr_out = st.serr;
	assign perr_resp = st.perr_resp;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	chk_claim_enable: assert property (
		mem_claim |-> $past(st.cmd_mem_en))
		else $error("claim without memory enable");

	chk_claim_match: assert property (
		mem_req && st.cmd_mem_en &&
		mem_addr[31:14] == st.base |=> mem_claim)
		else $error("matching request not claimed");

	chk_perr_sticky: assert property (
		parity_err_det |=> st.sts_perr)
		else $error("parity status not set");

	chk_perr_holds: assert property (
		st.sts_perr && !(wr_take && cfg_addr == 8'h04 && cfg_be[3]
		&& cfg_wdata[31]) |=> st.sts_perr)
		else $error("parity status lost without write");

	chk_serr_w1c: assert property (
		st.sts_serr && !sys_err_det && wr_take && cfg_addr == 8'h04
		&& cfg_be[3] && cfg_wdata[30] |=> !st.sts_serr)
		else $error("system error status not cleared");

	chk_intx_mask: assert property (
		intx_out |-> $past(uart_irq) && !$past(st.cmd_intx_dis))
		else $error("interrupt while disabled");

	chk_serr_gate: assert property (
		sys_err_det && st.cmd_serr_en |=> serr_out)
		else $error("system error not signalled");

	chk_perr_gate: assert property (
		perr_resp |-> $past(st.cmd_perr_en))
		else $error("parity response while ignored");

	chk_status_read: assert property (
		rd_take && cfg_addr == 8'h04 |=> ##1
		cfg_ack && cfg_rdata[29:16] == 14'h0010 && !cfg_rdata[0])
		else $error("status constant bits wrong");

	chk_misc_zero: assert property (
		rd_take && cfg_addr == 8'h0C |-> ##2 cfg_ack && cfg_rdata == '0)
		else $error("word at twelve not zero");

	chk_base_low: assert property (
		rd_take && cfg_addr == 8'h10 |-> ##2 cfg_rdata[13:0] == 14'h0)
		else $error("base low bits not zero");

	chk_rev_read: assert property (
		rd_take && cfg_addr == 8'h08 |-> ##2 cfg_rdata[7:0] == REV_ID)
		else $error("revision wrong");

	cov_read: cover property (rd_take ##2 cfg_ack);
	cov_claim: cover property (mem_claim);
	cov_w1c: cover property (st.sts_perr ##1 !st.sts_perr);
	cov_load: cover property (ee_valid);

endmodule : pcch_cfg_regs

// ==== tb/pcch_host_model.sv ====
// Host side: issues single configuration accesses
module pcch_host_model (
	// Clock
	input wire logic ref_clk,
	// Answer from the bank
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata,
	// Request
	output logic cfg_req,
	output logic cfg_we,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle request lines at time zero
	initial begin
		cfg_req = 1'b0;
		cfg_we = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h00000000;
	end

	// Base is programmed by the caller before window traffic
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		ok = 1'b0;
		q = 32'h00000000;
		@(posedge ref_clk);
		cfg_req <= 1'b1;
		cfg_we <= we;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge ref_clk);
		// Released address and data lines show garbage, not the last value
		cfg_req <= 1'b0;
		cfg_addr <= ~a;
		cfg_wdata <= ~d;
		for (int i = 0; i < 3 && !ok; i++) begin
			#1;
			if (cfg_ack === 1'b1) begin
				ok = 1'b1;
				q = cfg_rdata;
			end else begin
				@(posedge ref_clk);
			end
		end
	endtask : xfer
endmodule : pcch_host_model

// ==== tb/pci_config_header_regs_tb.sv ====
module pci_config_header_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] MK = 16'h1234; // arbitrary value
	localparam logic [15:0] DS = 16'h0A00; // arbitrary value
	localparam logic [15:0] D8 = 16'h0A08; // arbitrary value
	localparam logic [15:0] D4 = 16'h0A04; // arbitrary value
	localparam logic [7:0] RV = 8'h07; // arbitrary value
	logic ref_clk, arst_n, cfg_req, cfg_we, cfg_ack, ee_valid, mem_req;
	logic mem_claim, parity_err_det, sys_err_det, uart_irq, ok;
	logic intx_out, serr_out, perr_resp;
	logic [7:0] cfg_addr, m_il, m_ld;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, mem_addr, q, m_cmd, m_sts, m_base;
	logic [31:0] rs = 32'h0000005C;
	logic [2:0] ee_index;
	logic [15:0] ee_data;
	logic [15:0] m_w[8];
	logic [1:0] exp_slave;
	logic [7:0] offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h2C,
		8'h3C, 8'h14};
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;

	pcch_cfg_regs #(.MAKER_ID(MK), .DEV_ID_SOLO(DS), .DEV_ID_X8(D8),
		.DEV_ID_X4(D4), .REV_ID(RV)) dut_u (.ref_clk(ref_clk),
		.arst_n(arst_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .ee_valid(ee_valid),
		.ee_index(ee_index), .ee_data(ee_data), .exp_slave(exp_slave),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_claim(mem_claim),
		.parity_err_det(parity_err_det), .sys_err_det(sys_err_det),
		.uart_irq(uart_irq), .intx_out(intx_out), .serr_out(serr_out),
		.perr_resp(perr_resp));
	pcch_host_model host_u (.ref_clk(ref_clk), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata), .cfg_req(cfg_req), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

	// Free running clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Hang guard, far above the roughly 170 cycles needed
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			test_done();
		end
	end

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Model of what each word must read
	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		logic [15:0] dv;
		dv = exp_slave == 2'b01 ? D8 : exp_slave == 2'b10 ? D4 : DS;
		case (a)
			8'h00: return {m_ld[1] ? m_w[1] : dv, m_ld[0] ? m_w[0] : MK};
			8'h04: return m_sts | 32'h00100000 | m_cmd;
			8'h08: return {m_ld[2] ? m_w[2] : 16'h0700,
				m_ld[3] ? m_w[3][15:8] : 8'h02, RV};
			8'h10: return m_base;
			8'h2C: return {m_ld[5] ? m_w[5] : 16'h0000,
				m_ld[4] ? m_w[4] : 16'h0000};
			8'h3C: return {16'h0000, 8'h01, m_il};
			default: return 32'h00000000;
		endcase
	endfunction : exp_rd

	task automatic mrst();
		m_cmd = 32'h00000000;
		m_sts = 32'h00000000;
		m_base = 32'h00000000;
		m_il = 8'h00;
		m_ld = 8'h00;
	endtask : mrst

	task automatic rd(input logic [7:0] a);
		host_u.xfer(1'b0, a, 4'h0, 32'h00000000, q, ok);
		chk({31'h0, ok}, 32'h00000001);
		chk(q, exp_rd(a));
	endtask : rd

	// Write, then fold the effect into the model
	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		host_u.xfer(1'b1, a, be, d, q, ok);
		chk({31'h0, ok}, 32'h00000001);
		if (a == 8'h04) begin
			m_cmd = (m_cmd & ~bm) | (d & bm & 32'h00000542);
			m_sts = m_sts & ~(d & bm & 32'hC0000000);
		end
		if (a == 8'h10) begin
			m_base = (m_base & ~bm) | (d & bm & 32'hFFFFC000);
		end
		if (a == 8'h3C && be[0]) begin
			m_il = d[7:0];
		end
	endtask : wr

	task automatic ev(input logic p, input logic s);
		@(posedge ref_clk);
		parity_err_det <= p;
		sys_err_det <= s;
		@(posedge ref_clk);
		parity_err_det <= 1'b0;
		sys_err_det <= 1'b0;
		#1;
		chk({31'h0, perr_resp}, {31'h0, p & m_cmd[6]});
		chk({31'h0, serr_out}, {31'h0, s & m_cmd[8]});
		m_sts = m_sts | {p, s, 30'h0};
	endtask : ev

	task automatic mreq(input logic [31:0] a);
		@(posedge ref_clk);
		mem_req <= 1'b1;
		mem_addr <= a;
		@(posedge ref_clk);
		mem_req <= 1'b0;
		mem_addr <= ~a;
		#1;
		chk({31'h0, mem_claim},
			{31'h0, m_cmd[1] && a[31:14] == m_base[31:14]});
	endtask : mreq

	task automatic ld(input logic [2:0] i, input logic [15:0] d);
		@(posedge ref_clk);
		ee_valid <= 1'b1;
		ee_index <= i;
		ee_data <= d;
		@(posedge ref_clk);
		ee_valid <= 1'b0;
		ee_data <= ~d;
		m_w[i] = d;
		m_ld[i] = 1'b1;
	endtask : ld

	task automatic intx_chk();
		repeat (2) @(posedge ref_clk);
		#1;
		chk({31'h0, intx_out}, {31'h0, uart_irq & !m_cmd[10]});
	endtask : intx_chk

	task test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		{ee_valid, mem_req, parity_err_det, sys_err_det, uart_irq} = 5'h00;
		ee_index = 3'h0;
		ee_data = 16'h0000;
		mem_addr = 32'h00000000;
		exp_slave = 2'b00;
		arst_n = 1'b0;
		mrst();
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		foreach (offs[j]) rd(offs[j]);
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			exp_slave <= k[1:0];
			rd(8'h00);
		end
		wr(8'h04, 4'hF, 32'hFFFFFFFF);
		rd(8'h04);
		@(posedge ref_clk);
		uart_irq <= 1'b1;
		intx_chk();
		wr(8'h04, 4'h2, 32'h00000000);
		intx_chk();
		ev(1'b1, 1'b1);
		wr(8'h04, 4'hF, 32'h00000542);
		ev(1'b1, 1'b1);
		rd(8'h04);
		wr(8'h04, 4'h8, 32'h80000000);
		rd(8'h04);
		wr(8'h04, 4'hF, 32'h40000542);
		rd(8'h04);
		wr(8'h10, 4'hF, rnd());
		rd(8'h10);
		q = rnd();
		mreq({m_base[31:14], q[13:0]});
		mreq(m_base ^ 32'h00004000);
		wr(8'h04, 4'h1, 32'h00000000);
		mreq(m_base);
		wr(8'h14, 4'hF, 32'hFFFFFFFF);
		wr(8'h3C, 4'hF, rnd());
		for (int k = 0; k < 8; k++) begin
			q = rnd();
			ld(k[2:0], q[15:0]);
		end
		foreach (offs[j]) rd(offs[j]);
		// Second reset in mid-run must restore every default
		@(posedge ref_clk);
		arst_n <= 1'b0;
		@(posedge ref_clk);
		arst_n <= 1'b1;
		mrst();
		foreach (offs[j]) rd(offs[j]);
		test_done();
	end
endmodule : pci_config_header_regs_tb
